//--- rtl/adcc_pkg.sv
package adcc_pkg;
  // ==========================================================
  // register indexes (printed offsets) and apb byte addresses
  localparam logic [7:0] ADCC_IDX_RES_LO = 8'h78;
  localparam logic [7:0] ADCC_IDX_RES_HI = 8'h79;
  localparam logic [7:0] ADCC_IDX_CTRL_A = 8'h7a;
  localparam logic [7:0] ADCC_IDX_TRIG = 8'h7b;
  localparam logic [7:0] ADCC_IDX_MUX = 8'h7c;
  localparam int ADCC_AW = 12;
  localparam logic [11:0] ADCC_ADDR_RES_LO = {2'h0, ADCC_IDX_RES_LO, 2'h0};
  localparam logic [11:0] ADCC_ADDR_RES_HI = {2'h0, ADCC_IDX_RES_HI, 2'h0};
  localparam logic [11:0] ADCC_ADDR_CTRL_A = {2'h0, ADCC_IDX_CTRL_A, 2'h0};
  localparam logic [11:0] ADCC_ADDR_TRIG = {2'h0, ADCC_IDX_TRIG, 2'h0};
  localparam logic [11:0] ADCC_ADDR_MUX = {2'h0, ADCC_IDX_MUX, 2'h0};
  // ==========================================================
  // field positions
  localparam int ADCC_BIT_LEFT_ALIGN = 5;
  localparam int ADCC_BIT_ON = 7;
  localparam int ADCC_BIT_START = 6;
  localparam int ADCC_BIT_AUTO = 5;
  localparam int ADCC_BIT_DONE = 4;
  localparam int ADCC_BIT_IRQ_EN = 3;
  localparam int ADCC_LEFT_SHIFT = 6;
  // ==========================================================
  // reset values and cycle counts (in converter clock ticks)
  localparam logic [7:0] ADCC_RST_BYTE = 8'h00;
  localparam logic [9:0] ADCC_RST_RESULT = 10'h000;
  localparam logic [4:0] ADCC_FIRST_TICKS = 5'h19;
  localparam logic [4:0] ADCC_NORMAL_TICKS = 5'h0d;
  localparam logic [2:0] ADCC_SRC_FREE_RUN = 3'h0;
  localparam logic [4:0] ADCC_SEL_BANDGAP = 5'h1e;
  localparam logic [4:0] ADCC_SEL_GROUND = 5'h1f;
  localparam logic [1:0] ADCC_GAIN_1X = 2'h0;
  localparam logic [1:0] ADCC_GAIN_10X = 2'h1;
  localparam logic [1:0] ADCC_GAIN_200X = 2'h2;

  typedef enum logic {ADCC_PH_IDLE, ADCC_PH_CONV} adcc_phase_t;

  typedef struct packed {
    logic [7:0] input_gain_select;
    logic on;
    logic auto_trig;
    logic irq_en;
    logic [2:0] div_sel;
    logic [2:0] trig_src;
    logic done;
    logic [9:0] result;
    logic lock;
    adcc_phase_t phase;
    logic [6:0] pre_cnt;
    logic [4:0] tick_cnt;
    logic first_pending;
    logic long_conv;
    logic [4:0] act_sel;
    logic trig_prev;
  } adcc_state_t;

  typedef struct packed {
    logic [4:0] sel;
    logic diff;
    logic [1:0] gain;
  } adcc_route_t;
endpackage

//--- rtl/adcc_top.sv
// Our own choice: register access over APB.
`timescale 1ns/10ps
module adcc_top
  import adcc_pkg::*;
(
  input wire logic CORE_CLK_I,
  input wire logic NRST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [ADCC_AW-1:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic [7:0] TRIG_SRC_I,
  input wire logic GLOBAL_IRQ_EN_I,
  input wire logic IRQ_ACK_I,
  input wire logic [9:0] CORE_RESULT_I,
  output logic IRQ_O,
  output logic CONV_BUSY_O,
  output logic CONV_TICK_O,
  output logic [4:0] ACT_SEL_O,
  output logic ACT_DIFF_O,
  output logic [1:0] ACT_GAIN_O
);

  // ==========================================================
  // helpers
  function automatic logic [6:0] adcc_last_count(input logic [2:0] ps);
    logic [7:0] d;
    d = (ps == 3'h0) ? 8'h02 : (8'h01 << ps);
    return 7'(d - 8'h01);
  endfunction

  function automatic adcc_route_t adcc_decode(input logic [4:0] sel);
    adcc_route_t r;
    r.sel = sel;
    r.diff = (sel[4:3] != 2'h0) && (sel != ADCC_SEL_BANDGAP) && (sel != ADCC_SEL_GROUND);
    if (sel[4:3] == 2'h1) begin
      r.gain = sel[1] ? ADCC_GAIN_200X : ADCC_GAIN_10X;
    end else begin
      r.gain = ADCC_GAIN_1X;
    end
    return r;
  endfunction

  function automatic logic [15:0] adcc_align(input logic [9:0] res, input logic left);
    return left ? {res, 6'h00} : {6'h00, res};
  endfunction

  // ==========================================================
  // bus decode
  adcc_state_t s_reg;
  adcc_state_t s_next;
  logic acc;
  logic wr;
  logic rd;
  logic hit;
  logic wr_ctrl;
  logic start_req;
  logic tick;
  logic complete;
  logic trig_now;
  logic trig_edge;
  logic [15:0] res_view;
  logic res_held;
  adcc_route_t route;

  assign acc = PSEL_I & PENABLE_I;
  assign wr = acc & PWRITE_I & PSTRB_I[0];
  assign rd = acc & ~PWRITE_I;
  assign hit = (PADDR_I == ADCC_ADDR_RES_LO) || (PADDR_I == ADCC_ADDR_RES_HI) ||
               (PADDR_I == ADCC_ADDR_CTRL_A) || (PADDR_I == ADCC_ADDR_TRIG) ||
               (PADDR_I == ADCC_ADDR_MUX);
  // zero wait states keep the low/high read ordering simple to reason about
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = acc & ~hit;
  assign wr_ctrl = wr && (PADDR_I == ADCC_ADDR_CTRL_A);
  assign res_view = adcc_align(s_reg.result, s_reg.input_gain_select[ADCC_BIT_LEFT_ALIGN]);
  // a low read in the completing cycle must already hold the result, or the pair tears
  assign res_held = s_reg.lock || (rd && (PADDR_I == ADCC_ADDR_RES_LO));

  always_comb begin
    PRDATA_O = 32'h0000_0000;
    if (PADDR_I == ADCC_ADDR_RES_LO) begin
      PRDATA_O = {24'h00_0000, res_view[7:0]};
    end else if (PADDR_I == ADCC_ADDR_RES_HI) begin
      PRDATA_O = {24'h00_0000, res_view[15:8]};
    end else if (PADDR_I == ADCC_ADDR_CTRL_A) begin
      PRDATA_O = {24'h00_0000, s_reg.on, (s_reg.phase == ADCC_PH_CONV), s_reg.auto_trig,
                  s_reg.done, s_reg.irq_en, s_reg.div_sel};
    end else if (PADDR_I == ADCC_ADDR_TRIG) begin
      PRDATA_O = {29'h0000_0000, s_reg.trig_src};
    end else if (PADDR_I == ADCC_ADDR_MUX) begin
      PRDATA_O = {24'h00_0000, s_reg.input_gain_select};
    end
  end

  // ==========================================================
  // conversion sequencing
  // compare with >= so a smaller divider written mid count cannot run the counter round
  assign tick = s_reg.on && (s_reg.pre_cnt >= adcc_last_count(s_reg.div_sel));
  assign complete = (s_reg.phase == ADCC_PH_CONV) && tick &&
                    (s_reg.tick_cnt == 5'((s_reg.long_conv ? ADCC_FIRST_TICKS : ADCC_NORMAL_TICKS) - 5'h01));
  // source 0 is never sampled as an edge, so entering free run cannot fire a trigger
  assign trig_now = (s_reg.trig_src != ADCC_SRC_FREE_RUN) && TRIG_SRC_I[s_reg.trig_src];
  assign trig_edge = s_reg.auto_trig && trig_now && !s_reg.trig_prev;

  always_comb begin
    logic en_now;
    logic begin_conv;
    en_now = s_reg.on;
    begin_conv = 1'b0;
    s_next = s_reg;
    s_next.trig_prev = trig_now;
    start_req = 1'b0;
    // register writes
    if (wr && (PADDR_I == ADCC_ADDR_MUX)) begin
      s_next.input_gain_select = PWDATA_I[7:0];
    end
    if (wr && (PADDR_I == ADCC_ADDR_TRIG)) begin
      s_next.trig_src = PWDATA_I[2:0];
    end
    if (wr_ctrl) begin
      en_now = PWDATA_I[ADCC_BIT_ON];
      s_next.on = PWDATA_I[ADCC_BIT_ON];
      s_next.auto_trig = PWDATA_I[ADCC_BIT_AUTO];
      s_next.irq_en = PWDATA_I[ADCC_BIT_IRQ_EN];
      s_next.div_sel = PWDATA_I[2:0];
      start_req = PWDATA_I[ADCC_BIT_START];
      if (PWDATA_I[ADCC_BIT_ON] && !s_reg.on) begin
        s_next.first_pending = 1'b1;
      end
    end
    // prescaler
    if (!en_now || (wr_ctrl && !s_reg.on)) begin
      s_next.pre_cnt = 7'h00;
    end else if (tick) begin
      s_next.pre_cnt = 7'h00;
    end else begin
      s_next.pre_cnt = 7'(s_reg.pre_cnt + 7'h01);
    end
    // done flag: clear first, a completion in the same cycle wins
    if ((wr_ctrl && PWDATA_I[ADCC_BIT_DONE]) || IRQ_ACK_I) begin
      s_next.done = 1'b0;
    end
    // result lock
    if (rd && (PADDR_I == ADCC_ADDR_RES_LO)) begin
      s_next.lock = 1'b1;
    end
    if (rd && (PADDR_I == ADCC_ADDR_RES_HI)) begin
      s_next.lock = 1'b0;
    end
    case (s_reg.phase)
      ADCC_PH_IDLE: begin
        s_next.act_sel = s_next.input_gain_select[4:0];
        begin_conv = en_now && (start_req || trig_edge);
      end
      ADCC_PH_CONV: begin
        if (tick) begin
          s_next.tick_cnt = 5'(s_reg.tick_cnt + 5'h01);
        end
        if (complete) begin
          s_next.phase = ADCC_PH_IDLE;
          s_next.done = 1'b1;
          s_next.act_sel = s_next.input_gain_select[4:0];
          if (!res_held) begin
            s_next.result = CORE_RESULT_I;
          end
          begin_conv = en_now && ((s_reg.auto_trig && (s_reg.trig_src == ADCC_SRC_FREE_RUN)) || trig_edge);
        end
      end
      default: begin
        s_next.phase = ADCC_PH_IDLE;
      end
    endcase
    if (begin_conv) begin
      s_next.phase = ADCC_PH_CONV;
      s_next.tick_cnt = 5'h00;
      s_next.long_conv = s_next.first_pending;
      s_next.first_pending = 1'b0;
      s_next.act_sel = s_next.input_gain_select[4:0];
    end
    if (!en_now) begin
      s_next.phase = ADCC_PH_IDLE;
      s_next.tick_cnt = 5'h00;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      s_reg <= '{input_gain_select: ADCC_RST_BYTE, on: 1'b0, auto_trig: 1'b0, irq_en: 1'b0, div_sel: 3'h0,
                 trig_src: 3'h0, done: 1'b0, result: ADCC_RST_RESULT, lock: 1'b0,
                 phase: ADCC_PH_IDLE, pre_cnt: 7'h00, tick_cnt: 5'h00, first_pending: 1'b0,
                 long_conv: 1'b0, act_sel: 5'h00, trig_prev: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================================
  // outputs to the analog core and cpu
  assign route = adcc_decode(s_reg.act_sel);
  assign ACT_SEL_O = route.sel;
  assign ACT_DIFF_O = route.diff;
  assign ACT_GAIN_O = route.gain;
  assign CONV_BUSY_O = (s_reg.phase == ADCC_PH_CONV);
  assign CONV_TICK_O = tick;
  assign IRQ_O = s_reg.done & s_reg.irq_en & GLOBAL_IRQ_EN_I;

  // ==========================================================
  // checks
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!NRST_I);

  sequence s_low_read;
    rd && (PADDR_I == ADCC_ADDR_RES_LO);
  endsequence
  sequence s_no_high_read;
    !(rd && (PADDR_I == ADCC_ADDR_RES_HI));
  endsequence

  property p_left_zero;
    rd && s_reg.input_gain_select[ADCC_BIT_LEFT_ALIGN] && (PADDR_I == ADCC_ADDR_RES_LO) |-> PRDATA_O[5:0] == 6'h00;
  endproperty
  a_left_zero: assert property (p_left_zero) else $error("left aligned low bits not zero");

  property p_sel_hold;
    CONV_BUSY_O && !complete && s_reg.on |=> $stable(ACT_SEL_O);
  endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("selection changed mid conversion");

  property p_abort;
    wr_ctrl && !PWDATA_I[ADCC_BIT_ON] |=> !CONV_BUSY_O;
  endproperty
  a_abort: assert property (p_abort) else $error("disable did not abort");

  property p_length;
    complete |-> s_reg.tick_cnt == (s_reg.long_conv ? 5'h18 : 5'h0c);
  endproperty
  a_length: assert property (p_length) else $error("conversion length wrong");

  property p_done_result;
    complete && !res_held |=> s_reg.done && (s_reg.result == $past(CORE_RESULT_I));
  endproperty
  a_done_result: assert property (p_done_result) else $error("completion did not update");

  property p_irq;
    IRQ_O == (s_reg.done && s_reg.irq_en && GLOBAL_IRQ_EN_I);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt request mismatch");

  property p_lock;
    s_low_read ##1 s_no_high_read |-> $stable(s_reg.result);
  endproperty
  a_lock: assert property (p_lock) else $error("result changed while locked");

  property p_presc_off;
    !s_reg.on |-> s_reg.pre_cnt == 7'h00 && !CONV_TICK_O;
  endproperty
  a_presc_off: assert property (p_presc_off) else $error("prescaler ran while off");

  property p_free_run;
    complete && s_reg.on && s_reg.auto_trig && (s_reg.trig_src == ADCC_SRC_FREE_RUN) && !wr_ctrl
      |=> CONV_BUSY_O;
  endproperty
  a_free_run: assert property (p_free_run) else $error("free run did not restart");

  // ==========================================================
  // register view, decode and control checks
  sequence s_start_write;
    wr_ctrl && PWDATA_I[ADCC_BIT_ON] && PWDATA_I[ADCC_BIT_START];
  endsequence

  property p_right_view;
    rd && !s_reg.input_gain_select[ADCC_BIT_LEFT_ALIGN] && (PADDR_I == ADCC_ADDR_RES_HI) |-> PRDATA_O[7:2] == 6'h00;
  endproperty
  a_right_view: assert property (p_right_view) else $error("right aligned high bits not zero");

  property p_left_hi;
    rd && s_reg.input_gain_select[ADCC_BIT_LEFT_ALIGN] && (PADDR_I == ADCC_ADDR_RES_HI) |-> PRDATA_O[7:0] == s_reg.result[9:2];
  endproperty
  a_left_hi: assert property (p_left_hi) else $error("left aligned high byte wrong");

  property p_single;
    ACT_SEL_O[4:3] == 2'h0 |-> !ACT_DIFF_O && (ACT_GAIN_O == ADCC_GAIN_1X);
  endproperty
  a_single: assert property (p_single) else $error("single ended code decoded wrong");

  property p_fixed_src;
    ACT_SEL_O >= ADCC_SEL_BANDGAP |-> !ACT_DIFF_O && (ACT_GAIN_O == ADCC_GAIN_1X);
  endproperty
  a_fixed_src: assert property (p_fixed_src) else $error("bandgap or ground decoded wrong");

  property p_diff_gain;
    ACT_SEL_O[4:3] == 2'h1 |-> ACT_DIFF_O && (ACT_GAIN_O == (ACT_SEL_O[1] ? ADCC_GAIN_200X : ADCC_GAIN_10X));
  endproperty
  a_diff_gain: assert property (p_diff_gain) else $error("gain pair decoded wrong");

  property p_unity;
    ACT_SEL_O[4] && (ACT_SEL_O < ADCC_SEL_BANDGAP) |-> ACT_DIFF_O && (ACT_GAIN_O == ADCC_GAIN_1X);
  endproperty
  a_unity: assert property (p_unity) else $error("unity gain pair decoded wrong");

  property p_on_write;
    wr_ctrl |=> s_reg.on == $past(PWDATA_I[ADCC_BIT_ON]);
  endproperty
  a_on_write: assert property (p_on_write) else $error("enable bit not written");

  property p_start;
    s_start_write ##0 !CONV_BUSY_O |=> CONV_BUSY_O;
  endproperty
  a_start: assert property (p_start) else $error("start write did not begin");

  property p_first_long;
    s_start_write ##0 !s_reg.on |=> CONV_BUSY_O && s_reg.long_conv;
  endproperty
  a_first_long: assert property (p_first_long) else $error("first conversion not long");

  property p_busy_read;
    rd && (PADDR_I == ADCC_ADDR_CTRL_A) |-> PRDATA_O[ADCC_BIT_START] == CONV_BUSY_O;
  endproperty
  a_busy_read: assert property (p_busy_read) else $error("start bit does not show busy");

  property p_zero_start;
    wr_ctrl && !PWDATA_I[ADCC_BIT_START] && !CONV_BUSY_O && !trig_edge |=> !CONV_BUSY_O;
  endproperty
  a_zero_start: assert property (p_zero_start) else $error("zero start write began work");

  property p_trig;
    trig_edge && s_reg.on && !CONV_BUSY_O && !(wr_ctrl && !PWDATA_I[ADCC_BIT_ON]) |=> CONV_BUSY_O;
  endproperty
  a_trig: assert property (p_trig) else $error("trigger edge did not start");

  property p_done_clear;
    (IRQ_ACK_I || (wr_ctrl && PWDATA_I[ADCC_BIT_DONE])) && !complete |=> !s_reg.done;
  endproperty
  a_done_clear: assert property (p_done_clear) else $error("done flag not cleared");

  property p_set_wins;
    complete && (IRQ_ACK_I || (wr_ctrl && PWDATA_I[ADCC_BIT_DONE])) |=> s_reg.done;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat completion");

  property p_tick_gap;
    CONV_TICK_O |=> !CONV_TICK_O;
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("converter clock faster than half");

  property p_presc_restart;
    wr_ctrl && !s_reg.on |=> s_reg.pre_cnt == 7'h00;
  endproperty
  a_presc_restart: assert property (p_presc_restart) else $error("prescaler not restarted");

  property p_res_ro;
    wr && ((PADDR_I == ADCC_ADDR_RES_LO) || (PADDR_I == ADCC_ADDR_RES_HI)) && !complete |=> $stable(s_reg.result);
  endproperty
  a_res_ro: assert property (p_res_ro) else $error("result written by bus");

  property p_free_zero;
    wr && (PADDR_I == ADCC_ADDR_TRIG) && (PWDATA_I[2:0] == 3'h0) && !CONV_BUSY_O && !trig_edge |=> !CONV_BUSY_O;
  endproperty
  a_free_zero: assert property (p_free_zero) else $error("free run switch triggered");

endmodule // adcc_top

//--- verification/tb_top.sv
`timescale 1ns/10ps
// ==========================================================
// bench helpers
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin miscompares++; \
  $display("MISMATCH t=%0t got %0h exp %0h", $time, g, e); end end

module tb_top
  import adcc_pkg::*;
;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADCC_AW-1:0] paddr = '0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [7:0] trig = 8'h00;
  logic gie = 1'b0;
  logic ack = 1'b0;
  logic [9:0] core = 10'h270;
  logic [31:0] prdata;
  logic pready, pslverr, irq, busy, tick, diff;
  logic [4:0] asel;
  logic [1:0] gain;
  logic [31:0] rdat;
  logic rerr;
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;

  adcc_top u_dut (.CORE_CLK_I(clk), .NRST_I(nrst), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .TRIG_SRC_I(trig), .GLOBAL_IRQ_EN_I(gie), .IRQ_ACK_I(ack), .CORE_RESULT_I(core),
    .IRQ_O(irq), .CONV_BUSY_O(busy), .CONV_TICK_O(tick), .ACT_SEL_O(asel), .ACT_DIFF_O(diff),
    .ACT_GAIN_O(gain));

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic complete_run();
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // a hang ends the run through the same report
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      complete_run();
    end
  end

  // ==========================================================
  // apb master: returns at the edge where pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 8'h00);
  endtask

  // waits for a conversion and checks its tick count and length
  task automatic run_conv(input int nt, input int dv);
    int n;
    int t;
    n = 0;
    t = 0;
    while (busy !== 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    do begin
      if (tick === 1'b1) t++;
      @(negedge clk);
      n++;
    end while (busy === 1'b1 && n < 5000);
    `CHK(t, nt)
    `CHK(n >= (nt - 1) * dv && n <= (nt + 1) * dv, 1'b1)
  endtask

  function automatic logic [2:0] route(input int c);
    if (c >= 8 && c <= 15) return {1'b1, c[1] ? ADCC_GAIN_200X : ADCC_GAIN_10X};
    if (c >= 16 && c <= 29) return {1'b1, ADCC_GAIN_1X};
    return {1'b0, ADCC_GAIN_1X};
  endfunction

  // ==========================================================
  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    rd(ADCC_ADDR_RES_LO); `CHK(rdat, 32'h0)
    rd(ADCC_ADDR_RES_HI); `CHK(rdat, 32'h0)
    rd(ADCC_ADDR_CTRL_A); `CHK(rdat, 32'h0)
    rd(ADCC_ADDR_MUX); `CHK(rdat, 32'h0)
    rd(12'h000); `CHK({rerr, rdat}, 33'h100000000)
    wr(ADCC_ADDR_RES_LO, 8'h5a);
    rd(ADCC_ADDR_RES_LO); `CHK(rdat, 32'h0)
    rd(ADCC_ADDR_RES_HI); `CHK(rdat, 32'h0)
    for (int c = 0; c < 32; c++) begin
      wr(ADCC_ADDR_MUX, c[7:0]);
      @(negedge clk);
      `CHK({asel, diff, gain}, {c[4:0], route(c)})
    end
    wr(ADCC_ADDR_MUX, 8'h08);
    wr(ADCC_ADDR_CTRL_A, 8'hc0);
    run_conv(25, 2);
    rd(ADCC_ADDR_CTRL_A); `CHK(rdat, 32'h90)
    rd(ADCC_ADDR_RES_LO); `CHK(rdat, 32'h70)
    rd(ADCC_ADDR_RES_HI); `CHK(rdat, 32'h02)
    for (int d = 0; d < 8; d++) begin
      wr(ADCC_ADDR_CTRL_A, 8'hd0 | d[7:0]);
      if (d == 3) begin
        rd(ADCC_ADDR_CTRL_A); `CHK(rdat, 32'hc3)
        wr(ADCC_ADDR_CTRL_A, 8'h83);
        @(negedge clk); `CHK(busy, 1'b1)
        wr(ADCC_ADDR_MUX, 8'h25);
        rd(ADCC_ADDR_RES_HI); `CHK(rdat, 32'h9c)
        `CHK(asel, 5'h08)
        while (busy === 1'b1) @(negedge clk);
        `CHK(asel, 5'h05)
        wr(ADCC_ADDR_CTRL_A, 8'hd3);
      end
      run_conv(13, (d < 2) ? 2 : (1 << d));
    end
    rd(ADCC_ADDR_RES_LO); `CHK(rdat, 32'h00)
    core <= 10'h3ff;
    wr(ADCC_ADDR_CTRL_A, 8'hd1);
    run_conv(13, 2);
    rd(ADCC_ADDR_RES_HI); `CHK(rdat, 32'h9c)
    wr(ADCC_ADDR_CTRL_A, 8'hd1);
    run_conv(13, 2);
    rd(ADCC_ADDR_RES_HI); `CHK(rdat, 32'hff)
    wr(ADCC_ADDR_CTRL_A, 8'h88);
    gie <= 1'b1;
    @(negedge clk); `CHK(irq, 1'b1)
    @(posedge clk); gie <= 1'b0;
    @(negedge clk); `CHK(irq, 1'b0)
    @(posedge clk); gie <= 1'b1; ack <= 1'b1;
    @(posedge clk); ack <= 1'b0;
    @(negedge clk); `CHK(irq, 1'b0)
    rd(ADCC_ADDR_CTRL_A); `CHK(rdat, 32'h88)
    wr(ADCC_ADDR_CTRL_A, 8'hc9);
    repeat (6) @(posedge clk);
    wr(ADCC_ADDR_CTRL_A, 8'h08);
    @(negedge clk); `CHK(busy, 1'b0)
    repeat (60) @(posedge clk);
    rd(ADCC_ADDR_CTRL_A); `CHK(rdat, 32'h08)
    wr(ADCC_ADDR_CTRL_A, 8'hc1);
    run_conv(25, 2);
    wr(ADCC_ADDR_TRIG, 8'h01);
    wr(ADCC_ADDR_CTRL_A, 8'hb1);
    trig <= 8'h02;
    run_conv(13, 2);
    rd(ADCC_ADDR_CTRL_A); `CHK(rdat, 32'hb1)
    wr(ADCC_ADDR_TRIG, 8'h00);
    repeat (10) @(posedge clk);
    @(negedge clk); `CHK(busy, 1'b0)
    complete_run();
  end
endmodule // tb_top
